// >>> bzc_pkg.sv
/*
  bzc_pkg: address map, register layout, reset values and cycle counts
  for the bus interface zone control block.
  assumes a 24-bit byte address from the cpu core bus, 16-bit data.
*/
`default_nettype none
package bzc_pkg;
  // address map
  localparam logic [23:0] FLASH_LO = 24'h000000;
  localparam logic [23:0] FLASH_HI = 24'h03ffff;
  localparam logic [23:0] FDATA_LO = 24'h0d0000;
  localparam logic [23:0] FDATA_HI = 24'h0d1fff;
  localparam logic [23:0] RAM_LO = 24'h0e0000;
  localparam logic [23:0] RAM_HI = 24'h0e7fff;
  localparam logic [23:0] CAN0_LO = 24'h0ef000;
  localparam logic [23:0] CAN0_HI = 24'h0ef13f;
  localparam logic [23:0] CAN1_LO = 24'h0ef200;
  localparam logic [23:0] CAN1_HI = 24'h0ef33f;
  localparam logic [23:0] ZONE1_LO = 24'h400000;
  localparam logic [23:0] ZONE1_HI = 24'h7fffff;
  localparam logic [23:0] ZONE2_LO = 24'h800000;
  localparam logic [23:0] ZONE2_HI = 24'hfeffff;
  localparam logic [23:0] PERA_LO = 24'hfff200;
  localparam logic [23:0] PERA_HI = 24'hfffaff;
  localparam logic [23:0] IOZ_LO = 24'hfffb00;
  localparam logic [23:0] IOZ_HI = 24'hfffbff;
  localparam logic [23:0] PERB_LO = 24'hfffc00;
  localparam logic [23:0] PERB_HI = 24'hffffff;
  // bus control registers, two bytes apart
  localparam logic [23:0] BUS_GENERAL_CONFIG_ADDR = 24'hfff900;
  localparam logic [23:0] IO_ZONE_CONFIG_ADDR = 24'hfff902;
  localparam logic [23:0] STATIC_ZONE0_CONFIG_ADDR = 24'hfff904;
  localparam logic [23:0] STATIC_ZONE1_CONFIG_ADDR = 24'hfff906;
  localparam logic [23:0] STATIC_ZONE2_CONFIG_ADDR = 24'hfff908;
  // reset values and writable bits
  localparam logic [7:0] BUS_GENERAL_CONFIG_RESET = 8'h07;
  localparam logic [7:0] BUS_GENERAL_CONFIG_MASK = 8'h07;
  localparam logic [15:0] IO_ZONE_CONFIG_RESET = 16'h069f;
  localparam logic [15:0] IO_ZONE_CONFIG_MASK = 16'h069f;
  localparam logic [15:0] SZCFG_RESET = 16'h069f;
  localparam logic [15:0] SZCFG_MASK = 16'h0eff;
  // field positions
  localparam int WRITE_TIMING_BIT = 0;
  localparam int WAIT_LSB = 0;
  localparam int HOLD_LSB = 3;
  localparam int FAST_READ_BIT = 11;
  // basic cycle counts
  localparam logic [1:0] NORMAL_READ_CYCLES = 2'h2;
  localparam logic [1:0] FAST_READ_CYCLES = 2'h1;
  localparam logic [1:0] LATE_WRITE_CYCLES = 2'h2;
  localparam logic [1:0] EARLY_WRITE_CYCLES = 2'h3;
  localparam logic [1:0] UNTIMED_CYCLES = 2'h1;

  typedef enum logic [2:0] {
    MODE_INTERNAL_PROGRAM = 3'b000,
    MODE_EXTERNAL_PROGRAM = 3'b001,
    MODE_OFFCHIP_PROGRAM = 3'b010,
    MODE_OFFCHIP_KEEP_INTERNAL = 3'b011,
    MODE_IN_SYSTEM_PROGRAM = 3'b100
  } bzc_env_type;

  typedef enum logic [2:0] {
    TGT_NONE = 3'b000,
    TGT_FLASH = 3'b001,
    TGT_EXT = 3'b010,
    TGT_IO = 3'b011,
    TGT_ONCHIP = 3'b100,
    TGT_REGS = 3'b101
  } bzc_tgt_type;
endpackage
`default_nettype wire

// >>> bzc_env_select.sv
/*
  bzc_env_select: synchronises the environment strap pins and latches
  the operating environment while reset is held.
  assumes flash_empty comes from logic on sys_clk, straps from pads.
*/
`default_nettype none
module bzc_env_select import bzc_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [2:0] environment_strap_pins,
  input wire logic flash_empty,
  output bzc_env_type env_mode
);
  logic [2:0] strap_s1_q;
  logic [2:0] strap_s2_q;
  bzc_env_type mode_q;
  bzc_env_type mode_d;

  always_comb begin
    mode_d = mode_q;
    if (!rst_n) begin
      case (strap_s2_q)
        3'b111: mode_d = flash_empty ? MODE_IN_SYSTEM_PROGRAM : MODE_INTERNAL_PROGRAM;
        3'b011: mode_d = flash_empty ? MODE_IN_SYSTEM_PROGRAM : MODE_EXTERNAL_PROGRAM;
        3'b110: mode_d = MODE_IN_SYSTEM_PROGRAM;
        3'b000: mode_d = MODE_OFFCHIP_PROGRAM;
        3'b001: mode_d = MODE_OFFCHIP_KEEP_INTERNAL;
        // unlisted straps fall back to the safe boot loader
        default: mode_d = MODE_IN_SYSTEM_PROGRAM;
      endcase
    end
  end

  // straps are not reset: they must keep sampling during reset
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      strap_s1_q <= environment_strap_pins;
      strap_s2_q <= strap_s1_q;
      mode_q <= mode_d;
    end
  end

  assign env_mode = mode_q;

  isp_forced_a: assert property (@(posedge sys_clk)
    (!rst_n && clk_en && strap_s2_q == 3'b110) ##1 rst_n |-> env_mode == MODE_IN_SYSTEM_PROGRAM)
    else $error("strap 110 did not select in-system programming");
endmodule
`default_nettype wire

// >>> bzc_cycle_timer.sv
/*
  bzc_cycle_timer: paces one bus transfer: basic cycles, internal wait
  cycles right after the address, hold cycles at the end.
  assumes start is a one-cycle pulse given only while idle.
*/
`default_nettype none
module bzc_cycle_timer import bzc_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [1:0] base_cycles,
  input wire logic [2:0] wait_cycles,
  input wire logic [1:0] hold_cycles,
  output logic in_wait,
  output logic in_hold,
  output logic capture,
  output logic done
);
  logic [3:0] cnt_q, cnt_d, acc_q, acc_d, tot_q, tot_d;
  logic [2:0] wt_q, wt_d;
  logic busy_q, busy_d;

  always_comb begin
    cnt_d = cnt_q;
    acc_d = acc_q;
    tot_d = tot_q;
    wt_d = wt_q;
    busy_d = busy_q;
    if (start) begin
      cnt_d = 4'h0;
      acc_d = 4'({2'h0, base_cycles} + {1'b0, wait_cycles});
      tot_d = 4'({2'h0, base_cycles} + {1'b0, wait_cycles} + {2'h0, hold_cycles});
      wt_d = wait_cycles;
      busy_d = 1'b1;
    end else if (done) begin
      busy_d = 1'b0;
    end else if (busy_q) begin
      cnt_d = 4'(cnt_q + 4'h1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      acc_q <= 4'h0;
      tot_q <= 4'h0;
      wt_q <= 3'h0;
      busy_q <= 1'b0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
      acc_q <= acc_d;
      tot_q <= tot_d;
      wt_q <= wt_d;
      busy_q <= busy_d;
    end
  end

  assign in_wait = busy_q && cnt_q >= 4'h1 && cnt_q <= {1'b0, wt_q};
  assign capture = busy_q && cnt_q == 4'(acc_q - 4'h1);
  assign in_hold = busy_q && cnt_q >= acc_q;
  assign done = busy_q && cnt_q == 4'(tot_q - 4'h1);

  wait_after_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_n || !clk_en)
    start && wait_cycles != 3'h0 |=> !in_wait ##1 in_wait)
    else $error("wait cycle not right after address cycle");
  hold_at_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n || !clk_en)
    start && hold_cycles != 2'h0 |=> ##[1:12] (in_hold && !capture) ##0 (1'b1) [*1])
    else $error("hold cycles missing at end of transfer");
  fast_one_cycle_a: assert property (@(posedge sys_clk) disable iff (!rst_n || !clk_en)
    start && base_cycles == 2'h1 && wait_cycles == 3'h0 && hold_cycles == 2'h0 |=> done && capture)
    else $error("one-cycle transfer did not finish in one cycle");
  early_three_a: assert property (@(posedge sys_clk) disable iff (!rst_n || !clk_en)
    start && base_cycles == 2'h3 && wait_cycles == 3'h0 && hold_cycles == 2'h0 |=> !done [*2] ##1 done)
    else $error("three-cycle transfer length wrong");
endmodule
`default_nettype wire

// >>> bzc_zone_control.sv
/*
  bzc_zone_control: bus interface unit between the cpu core bus and the
  on-chip flash, the i/o zone, external memory and untimed on-chip regions.
  assumes a master that holds cpu_req and its address/data until cpu_ack,
  target read data on tgt_rdata from logic on sys_clk.
*/
`default_nettype none
module bzc_zone_control import bzc_pkg::*; #(
  parameter int DW = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [2:0] environment_strap_pins,
  input wire logic flash_empty,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [23:0] cpu_addr,
  input wire logic [DW-1:0] cpu_wdata,
  output logic cpu_ack,
  output logic cpu_err,
  output logic [DW-1:0] cpu_rdata,
  output logic [23:0] tgt_addr,
  output logic [DW-1:0] tgt_wdata,
  output logic tgt_we,
  output logic flash_sel,
  output logic ext_sel,
  output logic io_sel,
  output logic onchip_sel,
  output logic internal_wait_cycle,
  output logic hold_cycle,
  input wire logic [DW-1:0] tgt_rdata,
  output bzc_env_type env_mode,
  output logic ext_mem_enable,
  output logic isp_boot_select,
  output logic write_timing_select
);
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_XFER = 1'b1
  } bzc_state_type;

  function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
    return a >= lo && a <= hi;
  endfunction

  function automatic bzc_tgt_type decode_target(input logic [23:0] a, input bzc_env_type m);
    logic ext_ok;
    ext_ok = m == MODE_EXTERNAL_PROGRAM || m == MODE_OFFCHIP_PROGRAM || m == MODE_OFFCHIP_KEEP_INTERNAL;
    if (in_range(a, FLASH_LO, FLASH_HI) || in_range(a, FDATA_LO, FDATA_HI)) begin
      return m == MODE_OFFCHIP_PROGRAM ? TGT_EXT : TGT_FLASH;
    end
    if (in_range(a, ZONE1_LO, ZONE2_HI)) begin
      return ext_ok ? TGT_EXT : TGT_NONE;
    end
    if (in_range(a, BUS_GENERAL_CONFIG_ADDR, STATIC_ZONE2_CONFIG_ADDR + 24'h000001)) begin
      return TGT_REGS;
    end
    if (in_range(a, IOZ_LO, IOZ_HI)) begin
      return TGT_IO;
    end
    if (in_range(a, RAM_LO, RAM_HI) || in_range(a, CAN0_LO, CAN0_HI) || in_range(a, CAN1_LO, CAN1_HI) ||
        in_range(a, PERA_LO, PERA_HI) || in_range(a, PERB_LO, PERB_HI)) begin
      return TGT_ONCHIP;
    end
    // reserved holes answer with an error and no target strobe
    return TGT_NONE;
  endfunction

  bzc_state_type st_q, st_d;
  bzc_tgt_type tgt_q, tgt_d, req_tgt;
  logic [23:0] addr_q, addr_d;
  logic [DW-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic we_q, we_d, ack_q, ack_d, err_q, err_d;
  logic [7:0] bus_general_config_q, bus_general_config_d;
  logic [15:0] io_zone_config_q, io_zone_config_d;
  logic [15:0] sz_q [0:2];
  logic [15:0] sz_d [0:2];
  logic [15:0] reg_rd, zone_cfg;
  logic [1:0] zone_idx;
  logic accept, start, t_capture, t_done;
  logic [1:0] base_n, hold_n;
  logic [2:0] wait_n;

  bzc_env_select u_env (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .environment_strap_pins(environment_strap_pins),
    .flash_empty(flash_empty),
    .env_mode(env_mode)
  );

  bzc_cycle_timer u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .start(start),
    .base_cycles(base_n),
    .wait_cycles(wait_n),
    .hold_cycles(hold_n),
    .in_wait(internal_wait_cycle),
    .in_hold(hold_cycle),
    .capture(t_capture),
    .done(t_done)
  );

  assign req_tgt = decode_target(cpu_addr, env_mode);
  assign accept = st_q == ST_IDLE && cpu_req && !ack_q;
  assign start = accept;
  assign zone_idx = in_range(cpu_addr, ZONE2_LO, ZONE2_HI) ? 2'h2 :
                    in_range(cpu_addr, ZONE1_LO, ZONE1_HI) ? 2'h1 : 2'h0;
  assign zone_cfg = req_tgt == TGT_IO ? io_zone_config_q : sz_q[zone_idx];

  // cycle shape chosen from direction, target and zone settings
  always_comb begin
    base_n = UNTIMED_CYCLES;
    wait_n = 3'h0;
    hold_n = 2'h0;
    if (req_tgt == TGT_FLASH || req_tgt == TGT_EXT || req_tgt == TGT_IO) begin
      wait_n = zone_cfg[WAIT_LSB +: 3];
      hold_n = zone_cfg[HOLD_LSB +: 2];
      if (cpu_we) begin
        base_n = bus_general_config_q[WRITE_TIMING_BIT] ? EARLY_WRITE_CYCLES : LATE_WRITE_CYCLES;
      end else if (req_tgt != TGT_IO && zone_cfg[FAST_READ_BIT]) begin
        base_n = FAST_READ_CYCLES;
        // fast reads ignore the wait and hold fields
        wait_n = 3'h0;
        hold_n = 2'h0;
      end else begin
        base_n = NORMAL_READ_CYCLES;
      end
    end
  end

  always_comb begin
    case (addr_q[3:1])
      3'h0: reg_rd = {8'h00, bus_general_config_q};
      3'h1: reg_rd = io_zone_config_q;
      3'h2: reg_rd = sz_q[0];
      3'h3: reg_rd = sz_q[1];
      3'h4: reg_rd = sz_q[2];
      default: reg_rd = 16'h0000;
    endcase
  end

  // transfer sequencing
  always_comb begin
    st_d = st_q;
    tgt_d = tgt_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    we_d = we_q;
    rdata_d = rdata_q;
    err_d = err_q;
    ack_d = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (accept) begin
          st_d = ST_XFER;
          tgt_d = req_tgt;
          addr_d = cpu_addr;
          wdata_d = cpu_wdata;
          we_d = cpu_we;
        end
      end
      ST_XFER: begin
        if (t_capture && !we_q) begin
          rdata_d = tgt_q == TGT_REGS ? DW'(reg_rd) : tgt_q == TGT_NONE ? '0 : tgt_rdata;
        end
        if (t_done) begin
          st_d = ST_IDLE;
          tgt_d = TGT_NONE;
          ack_d = 1'b1;
          err_d = tgt_q == TGT_NONE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      tgt_q <= TGT_NONE;
      addr_q <= 24'h000000;
      wdata_q <= '0;
      we_q <= 1'b0;
      rdata_q <= '0;
      err_q <= 1'b0;
      ack_q <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
      tgt_q <= tgt_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      we_q <= we_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
      ack_q <= ack_d;
    end
  end

  // register writes commit on the last cycle of their transfer
  always_comb begin
    bus_general_config_d = bus_general_config_q;
    io_zone_config_d = io_zone_config_q;
    for (int i = 0; i < 3; i++) begin
      sz_d[i] = sz_q[i];
    end
    if (st_q == ST_XFER && t_done && we_q && tgt_q == TGT_REGS) begin
      case (addr_q[3:1])
        3'h0: bus_general_config_d = wdata_q[7:0] & BUS_GENERAL_CONFIG_MASK;
        3'h1: io_zone_config_d = 16'(wdata_q) & IO_ZONE_CONFIG_MASK;
        3'h2: sz_d[0] = 16'(wdata_q) & SZCFG_MASK;
        3'h3: sz_d[1] = 16'(wdata_q) & SZCFG_MASK;
        3'h4: sz_d[2] = 16'(wdata_q) & SZCFG_MASK;
        default: bus_general_config_d = bus_general_config_q;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_general_config_q <= BUS_GENERAL_CONFIG_RESET;
      io_zone_config_q <= IO_ZONE_CONFIG_RESET;
      for (int i = 0; i < 3; i++) begin
        sz_q[i] <= SZCFG_RESET;
      end
    end else if (clk_en) begin
      bus_general_config_q <= bus_general_config_d;
      io_zone_config_q <= io_zone_config_d;
      for (int i = 0; i < 3; i++) begin
        sz_q[i] <= sz_d[i];
      end
    end
  end

  // selects stay up through wait and hold so data is kept on the bus
  assign flash_sel = st_q == ST_XFER && tgt_q == TGT_FLASH;
  assign ext_sel = st_q == ST_XFER && tgt_q == TGT_EXT;
  assign io_sel = st_q == ST_XFER && tgt_q == TGT_IO;
  assign onchip_sel = st_q == ST_XFER && tgt_q == TGT_ONCHIP;
  assign tgt_addr = addr_q;
  assign tgt_wdata = wdata_q;
  assign tgt_we = we_q && st_q == ST_XFER && tgt_q != TGT_NONE && tgt_q != TGT_REGS;
  assign cpu_ack = ack_q;
  assign cpu_err = ack_q && err_q;
  assign cpu_rdata = rdata_q;
  assign write_timing_select = bus_general_config_q[WRITE_TIMING_BIT];
  assign ext_mem_enable = env_mode == MODE_EXTERNAL_PROGRAM || env_mode == MODE_OFFCHIP_PROGRAM ||
                          env_mode == MODE_OFFCHIP_KEEP_INTERNAL;
  assign isp_boot_select = env_mode == MODE_IN_SYSTEM_PROGRAM;

  sequence accept_s;
    accept;
  endsequence

  map_flash_a: assert property (@(posedge sys_clk) disable iff (!rst_n || !clk_en)
    accept_s ##0 in_range(cpu_addr, FLASH_LO, FLASH_HI) && env_mode != MODE_OFFCHIP_PROGRAM |=> flash_sel)
    else $error("program flash address not sent to flash");
  flash_data_a: assert property (@(posedge sys_clk) disable iff (!rst_n || !clk_en)
    accept_s ##0 in_range(cpu_addr, FDATA_LO, FDATA_HI) && env_mode != MODE_OFFCHIP_PROGRAM |=> flash_sel)
    else $error("flash data address not sent to flash");
  zone1_ext_a: assert property (@(posedge sys_clk) disable iff (!rst_n || !clk_en)
    accept_s ##0 in_range(cpu_addr, ZONE1_LO, ZONE1_HI) && ext_mem_enable |=> ext_sel)
    else $error("zone 1 access not routed external");
  zone2_ext_a: assert property (@(posedge sys_clk) disable iff (!rst_n || !clk_en)
    accept_s ##0 in_range(cpu_addr, ZONE2_LO, ZONE2_HI) && ext_mem_enable |=> ext_sel)
    else $error("zone 2 access not routed external");
  untimed_ram_a: assert property (@(posedge sys_clk) disable iff (!rst_n || !clk_en)
    accept_s ##0 in_range(cpu_addr, RAM_LO, RAM_HI) |=> onchip_sel && !internal_wait_cycle ##1 cpu_ack)
    else $error("system ram access was zone timed");
  offchip_zone0_a: assert property (@(posedge sys_clk) disable iff (!rst_n || !clk_en)
    accept_s ##0 in_range(cpu_addr, FLASH_LO, FLASH_HI) && env_mode == MODE_OFFCHIP_PROGRAM |=> ext_sel && !flash_sel)
    else $error("offchip mode left zone 0 on flash");
  keep_internal_a: assert property (@(posedge sys_clk) disable iff (!rst_n || !clk_en)
    accept_s ##0 in_range(cpu_addr, FLASH_LO, FLASH_HI) && env_mode == MODE_OFFCHIP_KEEP_INTERNAL |=> flash_sel)
    else $error("keep-internal mode moved zone 0 off chip");
  env_fixed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) |-> $stable(env_mode))
    else $error("environment changed outside reset");
  early_write_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !$past(rst_n) |-> bus_general_config_q == BUS_GENERAL_CONFIG_RESET && write_timing_select)
    else $error("bus config not 07h after reset");
  late_write_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n || !clk_en)
    accept_s ##0 cpu_we && !bus_general_config_q[0] && req_tgt == TGT_IO && io_zone_config_q[4:0] == 5'h00 |=> !cpu_ack ##1 !cpu_ack ##1 cpu_ack)
    else $error("late write to i/o zone not two cycles");
endmodule
`default_nettype wire

// >>> bzc_cpu_master.sv
/*
  bzc_cpu_master: cpu core bus master model, one transfer at a time.
  assumes the bench calls xfer from one process, on the design's clock.
*/
`default_nettype none
module bzc_cpu_master (
  input wire logic sys_clk,
  input wire logic cpu_ack,
  input wire logic cpu_err,
  input wire logic [15:0] cpu_rdata,
  output logic cpu_req,
  output logic cpu_we,
  output logic [23:0] cpu_addr,
  output logic [15:0] cpu_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cpu_req = 1'b0;
    cpu_we = 1'b0;
    cpu_addr = 24'h000000;
    cpu_wdata = 16'h0000;
  end
  // hold everything until ack is seen at a rising edge; n = rising edges seen, 40 means no answer
  task automatic xfer(input logic w, input logic [23:0] a, input logic [15:0] d,
                      output logic [15:0] rd, output logic er, output int n);
    @(posedge sys_clk);
    cpu_req <= 1'b1;
    cpu_we <= w;
    cpu_addr <= a;
    cpu_wdata <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cpu_ack !== 1'b1 && n < 40);
    // ack was taken at this edge, so the request may go now
    rd = cpu_rdata;
    er = cpu_err;
    cpu_req <= 1'b0;
    // released lines must not look like the last request
    cpu_addr <= ~a;
    cpu_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// >>> bus_interface_zone_control_bench.sv
/*
  bus_interface_zone_control_bench: self-checking bench for bzc_zone_control.
  assumes the cpu master model drives the bus and the bench plays the targets.
*/
`default_nettype none
module bus_interface_zone_control_bench import bzc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] BASE [4] = '{24'h000000, 24'h400000, 24'h800000, 24'hfffb00};
  localparam logic [23:0] SPAN [4] = '{24'h03fffe, 24'h3ffffe, 24'h3ffffe, 24'h0000fe};
  localparam logic [23:0] REGS [4] = '{STATIC_ZONE0_CONFIG_ADDR, STATIC_ZONE1_CONFIG_ADDR,
                                        STATIC_ZONE2_CONFIG_ADDR, IO_ZONE_CONFIG_ADDR};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] straps = 3'h7;
  logic empty = 1'b0;
  logic [15:0] trd = 16'h0000;
  logic req, we, ack, err, fsel, esel, isel, osel, wc, hc, ext_en, in_system_program_mode, wts, er, twe, swe;
  logic ce = 1'b1;
  logic [23:0] addr, taddr;
  logic [15:0] wd, rdata, rd, twd;
  logic [3:0] seen;
  logic [7:0] nw, nh;
  bzc_env_type env;
  int n;
  int mismatches = 0;
  int n_checks = 0;
  always #50 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    seen <= seen | {fsel, esel, isel, osel};
    nw <= nw + 8'(wc);
    nh <= nh + 8'(hc);
    swe <= swe | twe;
  end
  bzc_cpu_master u_bzc_cpu_master (.sys_clk(sys_clk), .cpu_ack(ack), .cpu_err(err), .cpu_rdata(rdata),
    .cpu_req(req), .cpu_we(we), .cpu_addr(addr), .cpu_wdata(wd));
  bzc_zone_control u_bzc_zone_control (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(ce),
    .environment_strap_pins(straps), .flash_empty(empty), .cpu_req(req), .cpu_we(we), .cpu_addr(addr),
    .cpu_wdata(wd), .cpu_ack(ack), .cpu_err(err), .cpu_rdata(rdata), .tgt_addr(taddr), .tgt_wdata(twd),
    .tgt_we(twe), .flash_sel(fsel), .ext_sel(esel), .io_sel(isel), .onchip_sel(osel),
    .internal_wait_cycle(wc), .hold_cycle(hc), .tgt_rdata(trd), .env_mode(env), .ext_mem_enable(ext_en),
    .isp_boot_select(in_system_program_mode), .write_timing_select(wts));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [23:0] a, input logic [15:0] d);
    seen = 4'h0;
    nw = 8'h00;
    nh = 8'h00;
    swe = 1'b0;
    u_bzc_cpu_master.xfer(w, a, d, rd, er, n);
    if (n >= 40) begin
      mismatches++;
      give_verdict();
    end
  endtask
  // straps move away right after release; the mode must not follow
  task automatic do_reset(input logic [2:0] s, input logic e);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    straps <= s;
    empty <= e;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    straps <= ~s;
    empty <= ~e;
    repeat (4) @(posedge sys_clk);
  endtask
  function automatic bzc_env_type exp_env(input logic [2:0] s, input logic e);
    case (s)
      3'b111: return e ? MODE_IN_SYSTEM_PROGRAM : MODE_INTERNAL_PROGRAM;
      3'b011: return e ? MODE_IN_SYSTEM_PROGRAM : MODE_EXTERNAL_PROGRAM;
      3'b000: return MODE_OFFCHIP_PROGRAM;
      3'b001: return MODE_OFFCHIP_KEEP_INTERNAL;
      default: return MODE_IN_SYSTEM_PROGRAM;
    endcase
  endfunction
  // rising edges from raising req to seeing ack: transfer cycles plus 2
  function automatic int exp_n(input logic w, input logic fast, input logic early, input logic [15:0] c);
    if (!w && fast) return 3;
    return (w && early ? 3 : 2) + c[2:0] + c[4:3] + 2;
  endfunction
  initial begin
    logic [15:0] cfg;
    logic [15:0] d;
    logic [1:0] z;
    logic w, early, fast;
    logic [23:0] a;
    bzc_env_type m;
    void'($urandom(11));
    for (int i = 0; i < 16; i++) begin
      do_reset(i[2:0], i[3]);
      m = exp_env(i[2:0], i[3]);
      chk(env, m);
      chk(ext_en, m inside {MODE_EXTERNAL_PROGRAM, MODE_OFFCHIP_PROGRAM, MODE_OFFCHIP_KEEP_INTERNAL});
      chk(in_system_program_mode, m == MODE_IN_SYSTEM_PROGRAM);
    end
    $display("environment test done");
    do_reset(3'b000, 1'b0);
    acc(1'b0, 24'h000100, 16'h0000);
    chk(seen, 4'b0100);
    do_reset(3'b001, 1'b0);
    acc(1'b0, 24'h000100, 16'h0000);
    chk(seen, 4'b1000);
    do_reset(3'b111, 1'b0);
    acc(1'b0, FDATA_LO, 16'h0000);
    chk(seen, 4'b1000);
    acc(1'b0, ZONE1_LO, 16'h0000);
    chk({er, seen}, 5'b10000);
    $display("routing test done");
    do_reset(3'b011, 1'b0);
    chk(wts, 1'b1);
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, BUS_GENERAL_CONFIG_ADDR + 24'(2 * i), 16'h0000);
      chk(rd, i == 0 ? 16'h0007 : 16'h069f);
    end
    $display("register test done");
    for (int i = 0; i < 14; i++) begin
      // corners first: late, then early i/o write with no extra cycles, then all of them
      z = i < 2 ? 2'h3 : 2'($urandom_range(3));
      cfg = i < 2 ? 16'h0000 : i == 2 ? 16'h001f : 16'($urandom());
      early = i < 2 ? 1'(i) : 1'($urandom());
      w = i < 2 ? 1'b1 : 1'($urandom());
      a = BASE[z] + (24'($urandom()) & SPAN[z]);
      acc(1'b1, REGS[z], cfg);
      cfg = cfg & (z == 3 ? 16'h069f : 16'h0eff);
      acc(1'b0, REGS[z], 16'h0000);
      chk(rd, cfg);
      acc(1'b1, BUS_GENERAL_CONFIG_ADDR, {13'h0000, 2'b11, early});
      chk(wts, early);
      fast = z != 3 && cfg[11];
      trd <= 16'($urandom());
      d = 16'($urandom());
      acc(w, a, d);
      chk(n, exp_n(w, fast, early, cfg));
      chk(nw, !w && fast ? 8'h00 : 8'(cfg[2:0]));
      chk(nh, !w && fast ? 8'h00 : 8'(cfg[4:3]));
      chk(seen, z == 3 ? 4'b0010 : z == 0 ? 4'b1000 : 4'b0100);
      chk(taddr, a);
      chk(swe, w);
      if (w) chk(twd, d);
      if (!w) chk(rd, trd);
    end
    $display("timing test done");
    acc(1'b0, RAM_LO, 16'h0000);
    chk({n[7:0], seen}, {8'd3, 4'b0001});
    acc(1'b1, 24'h0d2000, 16'hffff);
    chk({er, seen, n[7:0], swe}, {5'b10000, 8'd3, 1'b0});
    // clock enable low for three edges mid-transfer stretches it by three
    fork
      acc(1'b0, RAM_LO, 16'h0000);
      begin
        repeat (2) @(posedge sys_clk);
        ce <= 1'b0;
        repeat (3) @(posedge sys_clk);
        ce <= 1'b1;
      end
    join
    chk({n[7:0], seen}, {8'd6, 4'b0001});
    $display("untimed test done");
    give_verdict();
  end
endmodule
`default_nettype wire
